//--- include/vcfg_pkg.sv
package vcfg_pkg;
  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h44;
  localparam int NREG = 8;
  localparam logic [7:0] REG_ADDR [NREG] =
    '{8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h37, 8'h38, 8'h39};
  localparam logic [7:0] REG_RST [NREG] =
    '{8'h1d, 8'h00, 8'h00, 8'h00, 8'hb4, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] REG_MASK [NREG] =
    '{8'hbf, 8'hff, 8'hff, 8'h8f, 8'hfe, 8'hfc, 8'h1f, 8'h1f};
  localparam int IDX_SYNC = 0;
  localparam int IDX_CG0 = 1;
  localparam int IDX_CG1 = 2;
  localparam int IDX_CG2 = 3;
  localparam int IDX_ROUTE = 4;
  localparam int IDX_SCALE = 5;
  localparam int IDX_YGAIN = 6;
  localparam int IDX_CGAIN = 7;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SYNC_RESET_SELECT_BIT = 7;
  localparam int BE_MSB = 5;
  localparam int COPY_GEN_OUTPUT_ON_BIT = 7;
  localparam int CG2_MSB = 3;
  localparam int GSEL_BIT = 7;
  localparam int GCOMP_BIT = 6;
  localparam int BCOMP_BIT = 5;
  localparam int RCHROMA_BIT = 4;
  localparam int BYPASS_BIT = 3;
  localparam int CLK2_BIT = 2;
  localparam int RCOMP_BIT = 1;
  localparam int VUP_BIT = 7;
  localparam int VFIL_MSB = 6;
  localparam int VFIL_LSB = 5;
  localparam int ZOOM_BIT = 4;
  localparam int RANGE_BIT = 3;
  localparam int HORIZONTAL_INTERP_ON_BIT = 2;
  localparam int GAIN_MSB = 4;
  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [1:0] VF_NONE = 2'h0;
  localparam logic [1:0] VF_RESERVED = 2'h3;
  localparam logic [7:0] LIM_BLACK = 8'h10;
  localparam logic [7:0] LIM_WHITE = 8'heb;
  localparam logic [7:0] FULL_BLACK = 8'h00;
  localparam logic [7:0] FULL_WHITE = 8'hff;
  localparam logic [5:0] GAIN_UNITY = 6'h20;
  localparam logic [4:0] CG_BITS = 5'h14;
  typedef enum logic [1:0] {SRC_LUMA, SRC_COMPOSITE, SRC_COMPONENT, SRC_CHROMA} vcfg_src_t;
endpackage

//--- core/vcfg_sync2.sv
module vcfg_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Asynchronous in, synchronous out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      meta_q <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

//--- core/vcfg_byte_reg.sv
module vcfg_byte_reg #(
  parameter logic [7:0] ADDR = 8'h00,
  parameter logic [7:0] RST = 8'h00,
  parameter logic [7:0] MASK = 8'hff
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Write port
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  // Stored value
  output logic [7:0] o_q
);
  wire hit = i_wr_en && (i_wr_addr == ADDR);

  // Reserved bits never store, so they read back as zero
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_q <= RST;
    else if (hit)
      o_q <= i_wr_data & MASK;
  end
endmodule

//--- core/vcfg_output_config.sv
module vcfg_output_config (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // I2C slave pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Shared teletext / sync reset pin
  input wire logic i_teletext_or_sync_reset_pin,
  output logic o_teletext_bit,
  output logic o_sync_restart,
  // Shared teletext request / clock pin
  input wire logic i_teletext_request,
  output logic o_teletext_request_or_clock_pin,
  // Copy generation insertion
  input wire logic i_cg_runin_done,
  input wire logic i_cg_bit_strobe,
  output logic o_copy_gen_bit,
  output logic o_copy_gen_bit_valid,
  // DAC routing
  output vcfg_pkg::vcfg_src_t o_green_luma_composite_src,
  output vcfg_pkg::vcfg_src_t o_blue_composite_src,
  output vcfg_pkg::vcfg_src_t o_red_chroma_composite_src,
  output logic o_encoder_bypass,
  // Encoder controls
  output logic [5:0] o_burst_end_point,
  output logic o_vertical_upscale_on,
  output logic [1:0] o_vertical_filter_place,
  output logic o_cursor_double_size,
  output logic o_horizontal_interp_on,
  output logic [7:0] o_input_black_level,
  output logic [7:0] o_input_white_level,
  output logic [5:0] o_luma_gain_32nds,
  output logic [5:0] o_colour_diff_gain_32nds
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_SUB, ST_WRITE, ST_READ} vcfg_i2c_state_t;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [2:0] pin_s;
  logic scl_p_q;
  logic sda_p_q;
  logic ttx_p_q;

  vcfg_sync2 #(.W(3)) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_teletext_or_sync_reset_pin, i_sda, i_scl}),
    .o_sync(pin_s)
  );

  wire scl_s = pin_s[0];
  wire sda_s = pin_s[1];
  wire ttx_s = pin_s[2];
  wire scl_rise = scl_s && !scl_p_q;
  wire scl_fall = !scl_s && scl_p_q;
  wire bus_start = scl_s && scl_p_q && sda_p_q && !sda_s;
  wire bus_stop = scl_s && scl_p_q && !sda_p_q && sda_s;

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      ttx_p_q <= 1'b0;
    end
    else
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      ttx_p_q <= ttx_s;
    end
  end

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  logic [7:0] regs [vcfg_pkg::NREG];
  logic wr_en;
  logic [7:0] sub_q;
  logic [7:0] sh_q;

  for (genvar g = 0; g < vcfg_pkg::NREG; g++)
  begin : g_reg
    vcfg_byte_reg #(
      .ADDR(vcfg_pkg::REG_ADDR[g]),
      .RST(vcfg_pkg::REG_RST[g]),
      .MASK(vcfg_pkg::REG_MASK[g])
    ) u_reg (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_wr_en(wr_en),
      .i_wr_addr(sub_q),
      .i_wr_data(sh_q),
      .o_q(regs[g])
    );
  end

  // ----------------------------------------------------------------
  // I2C slave
  // ----------------------------------------------------------------
  vcfg_i2c_state_t st_q;
  vcfg_i2c_state_t st_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [7:0] sh_d;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic [7:0] sub_d;
  logic oe_d;
  logic ack_q;
  logic ack_d;
  logic rw_q;
  logic rw_d;
  logic nack_q;
  logic nack_d;
  logic load;
  logic [7:0] rd_data;

  // A read after the first byte fetches from the next subaddress
  wire [7:0] rd_addr = (st_q == ST_READ) ? sub_q + 8'h01 : sub_q;

  // Unmapped subaddresses read as zero and swallow writes
  always_comb
  begin
    rd_data = 8'h00;
    for (int i = 0; i < vcfg_pkg::NREG; i++)
      if (rd_addr == vcfg_pkg::REG_ADDR[i])
        rd_data = regs[i];
  end

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    sub_d = sub_q;
    oe_d = o_sda_oe;
    ack_d = ack_q;
    rw_d = rw_q;
    nack_d = nack_q;
    wr_en = 1'b0;
    load = 1'b0;
    if (bus_start)
    begin
      st_d = ST_ADDR;
      cnt_d = 4'h0;
      ack_d = 1'b0;
      oe_d = 1'b0;
    end
    else if (bus_stop)
    begin
      st_d = ST_IDLE;
      ack_d = 1'b0;
      oe_d = 1'b0;
    end
    else if (st_q != ST_IDLE && scl_rise)
    begin
      if (ack_q)
        nack_d = sda_s;
      else
      begin
        sh_d = {sh_q[6:0], sda_s};
        cnt_d = cnt_q + 4'h1;
      end
    end
    else if (st_q != ST_IDLE && scl_fall)
    begin
      if (ack_q)
      begin
        ack_d = 1'b0;
        oe_d = 1'b0;
        unique case (st_q)
          ST_ADDR:
          begin
            st_d = rw_q ? ST_READ : ST_SUB;
            load = rw_q;
          end
          ST_SUB:
            st_d = ST_WRITE;
          ST_WRITE:
            st_d = ST_WRITE;
          ST_READ:
          begin
            if (nack_q)
              st_d = ST_IDLE;
            else
            begin
              sub_d = rd_addr;
              load = 1'b1;
            end
          end
          ST_IDLE:
            st_d = ST_IDLE;
        endcase
      end
      else if (cnt_q == 4'h8)
      begin
        cnt_d = 4'h0;
        ack_d = 1'b1;
        oe_d = 1'b1;
        unique case (st_q)
          ST_ADDR:
          begin
            rw_d = sh_q[0];
            if (sh_q[7:1] != vcfg_pkg::DEV_ADDR)
            begin
              st_d = ST_IDLE;
              ack_d = 1'b0;
              oe_d = 1'b0;
            end
          end
          ST_SUB:
            sub_d = sh_q;
          ST_WRITE:
          begin
            wr_en = 1'b1;
            sub_d = sub_q + 8'h01;
          end
          ST_READ:
            oe_d = 1'b0;
          ST_IDLE:
            oe_d = 1'b0;
        endcase
      end
      else if (st_q == ST_READ)
      begin
        tx_d = {tx_q[6:0], 1'b0};
        oe_d = !tx_q[6];
      end
    end
    if (load)
    begin
      tx_d = rd_data;
      oe_d = !rd_data[7];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      sub_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      sub_q <= sub_d;
    end
  end

  // Open-drain: only ever pulls low
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_sda_oe <= 1'b0;
      o_sda_out <= 1'b0;
      ack_q <= 1'b0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
    end
    else
    begin
      o_sda_oe <= oe_d;
      o_sda_out <= 1'b0;
      ack_q <= ack_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire sync_reset_select_sel = regs[vcfg_pkg::IDX_SYNC][vcfg_pkg::SYNC_RESET_SELECT_BIT];
  wire cg_on = regs[vcfg_pkg::IDX_CG2][vcfg_pkg::COPY_GEN_OUTPUT_ON_BIT];
  wire [7:0] route = regs[vcfg_pkg::IDX_ROUTE];
  wire [7:0] scale = regs[vcfg_pkg::IDX_SCALE];
  wire bypass = route[vcfg_pkg::BYPASS_BIT];
  wire clk2_on = route[vcfg_pkg::CLK2_BIT];
  wire [1:0] vfil = scale[vcfg_pkg::VFIL_MSB:vcfg_pkg::VFIL_LSB];
  wire vup = scale[vcfg_pkg::VUP_BIT];
  wire full_range = scale[vcfg_pkg::RANGE_BIT];
  wire [4:0] ygain = regs[vcfg_pkg::IDX_YGAIN][vcfg_pkg::GAIN_MSB:0];
  wire [4:0] cgain = regs[vcfg_pkg::IDX_CGAIN][vcfg_pkg::GAIN_MSB:0];

  // Composite enables win over the component selects
  wire vcfg_pkg::vcfg_src_t green_src = bypass ? vcfg_pkg::SRC_COMPONENT :
    route[vcfg_pkg::GCOMP_BIT] ? vcfg_pkg::SRC_COMPOSITE :
    route[vcfg_pkg::GSEL_BIT] ? vcfg_pkg::SRC_LUMA : vcfg_pkg::SRC_COMPONENT;
  wire vcfg_pkg::vcfg_src_t blue_src = bypass ? vcfg_pkg::SRC_COMPONENT :
    route[vcfg_pkg::BCOMP_BIT] ? vcfg_pkg::SRC_COMPOSITE : vcfg_pkg::SRC_COMPONENT;
  wire vcfg_pkg::vcfg_src_t red_src = bypass ? vcfg_pkg::SRC_COMPONENT :
    route[vcfg_pkg::RCOMP_BIT] ? vcfg_pkg::SRC_COMPOSITE :
    route[vcfg_pkg::RCHROMA_BIT] ? vcfg_pkg::SRC_CHROMA : vcfg_pkg::SRC_COMPONENT;

  // Reserved filter code and upscaling both leave the filter out
  wire [1:0] vfil_eff = (vup || vfil == vcfg_pkg::VF_RESERVED) ? vcfg_pkg::VF_NONE : vfil;

  // Two's complement field centred on unity gain, in 32nds
  wire [5:0] ygain_32 = vcfg_pkg::GAIN_UNITY + {ygain[4], ygain};
  wire [5:0] cgain_32 = vcfg_pkg::GAIN_UNITY + {cgain[4], cgain};

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_green_luma_composite_src <= vcfg_pkg::SRC_LUMA;
      o_blue_composite_src <= vcfg_pkg::SRC_COMPOSITE;
      o_red_chroma_composite_src <= vcfg_pkg::SRC_CHROMA;
      o_encoder_bypass <= 1'b0;
      o_burst_end_point <= vcfg_pkg::REG_RST[vcfg_pkg::IDX_SYNC][vcfg_pkg::BE_MSB:0];
      o_vertical_upscale_on <= 1'b0;
      o_vertical_filter_place <= vcfg_pkg::VF_NONE;
      o_cursor_double_size <= 1'b0;
      o_horizontal_interp_on <= 1'b0;
    end
    else
    begin
      o_green_luma_composite_src <= green_src;
      o_blue_composite_src <= blue_src;
      o_red_chroma_composite_src <= red_src;
      o_encoder_bypass <= bypass;
      o_burst_end_point <= regs[vcfg_pkg::IDX_SYNC][vcfg_pkg::BE_MSB:0];
      o_vertical_upscale_on <= vup;
      o_vertical_filter_place <= vfil_eff;
      o_cursor_double_size <= scale[vcfg_pkg::ZOOM_BIT];
      o_horizontal_interp_on <= scale[vcfg_pkg::HORIZONTAL_INTERP_ON_BIT];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_input_black_level <= vcfg_pkg::LIM_BLACK;
      o_input_white_level <= vcfg_pkg::LIM_WHITE;
      o_luma_gain_32nds <= vcfg_pkg::GAIN_UNITY;
      o_colour_diff_gain_32nds <= vcfg_pkg::GAIN_UNITY;
    end
    else
    begin
      o_input_black_level <= full_range ? vcfg_pkg::FULL_BLACK : vcfg_pkg::LIM_BLACK;
      o_input_white_level <= full_range ? vcfg_pkg::FULL_WHITE : vcfg_pkg::LIM_WHITE;
      o_luma_gain_32nds <= ygain_32;
      o_colour_diff_gain_32nds <= cgain_32;
    end
  end

  // ----------------------------------------------------------------
  // Shared pins
  // ----------------------------------------------------------------
  // The clock half rate is made by toggling the pin flop itself
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_teletext_bit <= 1'b0;
      o_sync_restart <= 1'b0;
      o_teletext_request_or_clock_pin <= 1'b0;
    end
    else
    begin
      o_teletext_bit <= !sync_reset_select_sel && ttx_s;
      o_sync_restart <= sync_reset_select_sel && ttx_s && !ttx_p_q;
      o_teletext_request_or_clock_pin <= clk2_on ?
        !o_teletext_request_or_clock_pin : i_teletext_request;
    end
  end

  // ----------------------------------------------------------------
  // Copy generation serialiser
  // ----------------------------------------------------------------
  // Bytes are snapshotted at run-in so a write mid-line cannot tear a word
  logic [4:0] cg_cnt_q;
  logic [19:0] cg_sr_q;
  wire [19:0] cg_word = {regs[vcfg_pkg::IDX_CG2][vcfg_pkg::CG2_MSB:0],
    regs[vcfg_pkg::IDX_CG1], regs[vcfg_pkg::IDX_CG0]};
  wire cg_load = i_cg_runin_done && cg_on;
  wire cg_shift = i_cg_bit_strobe && (cg_cnt_q != 5'h00);

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cg_cnt_q <= 5'h00;
      cg_sr_q <= 20'h00000;
      o_copy_gen_bit <= 1'b0;
      o_copy_gen_bit_valid <= 1'b0;
    end
    else if (cg_load)
    begin
      cg_cnt_q <= vcfg_pkg::CG_BITS;
      cg_sr_q <= cg_word;
      o_copy_gen_bit_valid <= 1'b0;
    end
    else
    begin
      o_copy_gen_bit_valid <= cg_shift;
      if (cg_shift)
      begin
        o_copy_gen_bit <= cg_sr_q[0];
        cg_sr_q <= {1'b0, cg_sr_q[19:1]};
        cg_cnt_q <= cg_cnt_q - 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  ttx_bit_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_teletext_bit |-> !$past(sync_reset_select_sel) && !o_sync_restart)
    else $error("teletext bit seen while sync reset selected");
  sync_restart_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (sync_reset_select_sel && ttx_s && !ttx_p_q) |=> o_sync_restart ##1 !o_sync_restart)
    else $error("sync restart not a one-cycle pulse");
  burst_end_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $changed(regs[vcfg_pkg::IDX_SYNC]) |=> o_burst_end_point == $past(regs[0][5:0]))
    else $error("burst end output does not follow register");
  cg_lsb_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (cg_load ##1 (i_cg_bit_strobe && !cg_load))
      |=> o_copy_gen_bit_valid && o_copy_gen_bit == $past(cg_sr_q[0]) &&
      cg_cnt_q == 5'h13)
    else $error("copy generation first bit not lsb");
  cg_gate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!cg_on && cg_cnt_q == 5'h00) |=> !o_copy_gen_bit_valid[*2])
    else $error("copy generation data while disabled");
  green_route_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!bypass && route[vcfg_pkg::GCOMP_BIT])
      |=> o_green_luma_composite_src == vcfg_pkg::SRC_COMPOSITE)
    else $error("green pin not composite");
  red_route_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!bypass && !route[vcfg_pkg::RCOMP_BIT] && route[vcfg_pkg::RCHROMA_BIT])
      |=> o_red_chroma_composite_src == vcfg_pkg::SRC_CHROMA)
    else $error("red pin ignores chroma select");
  bypass_route_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    bypass |=> o_blue_composite_src == vcfg_pkg::SRC_COMPONENT &&
      o_green_luma_composite_src == vcfg_pkg::SRC_COMPONENT && o_encoder_bypass)
    else $error("bypass does not route rgb");
  clock_out_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (clk2_on && $past(clk2_on)) |=> $changed(o_teletext_request_or_clock_pin))
    else $error("clock output not toggling");
  vfilter_off_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    vup |=> o_vertical_filter_place == vcfg_pkg::VF_NONE)
    else $error("vertical filter active while upscaling");
  auto_inc_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wr_en |=> sub_q == $past(sub_q) + 8'h01)
    else $error("subaddress did not increment after write");
endmodule

//--- verif/vcfg_i2c_host.sv
module vcfg_i2c_host (
  // Bus pins
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  int nak = 0;
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // Five clocks a phase, three above the slave's minimum
  task automatic ph;
    repeat (5) @(negedge i_clk);
  endtask
  task automatic ln(input logic v);
    ph();
    o_sda_low <= v;
  endtask
  task automatic ck(input logic v);
    ph();
    o_scl <= v;
  endtask
  // A one releases the line, so the same slot reads the slave
  task automatic bx(input logic b, output logic r);
    ln(~b);
    ck(1'b1);
    ph();
    r = i_sda;
    o_scl <= 1'b0;
  endtask
  task automatic xf(input logic [7:0] d, input logic l, k, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--)
      bx(d[i], r[i]);
    bx(l, a);
    if (k && a !== 1'b0)
      nak++;
  endtask
  task automatic st;
    ln(1'b0);
    ck(1'b1);
    ln(1'b1);
    ck(1'b0);
  endtask
  task automatic sp;
    ln(1'b1);
    ck(1'b1);
    ln(1'b0);
    ph();
  endtask
  task automatic wr(input logic [7:0] s, d0, d1);
    logic [7:0] r;
    st();
    xf({vcfg_pkg::DEV_ADDR, 1'b0}, 1'b1, 1'b1, r);
    xf(s, 1'b1, 1'b1, r);
    xf(d0, 1'b1, 1'b1, r);
    xf(d1, 1'b1, 1'b1, r);
    sp();
  endtask
  task automatic rd(input logic [7:0] s, output logic [7:0] q0, q1);
    logic [7:0] r;
    st();
    xf({vcfg_pkg::DEV_ADDR, 1'b0}, 1'b1, 1'b1, r);
    xf(s, 1'b1, 1'b1, r);
    st();
    xf({vcfg_pkg::DEV_ADDR, 1'b1}, 1'b1, 1'b1, r);
    xf(8'hff, 1'b0, 1'b0, q0);
    xf(8'hff, 1'b1, 1'b0, q1);
    sp();
  endtask
endmodule

//--- verif/video_encoder_output_config_regs_bench.sv
module video_encoder_output_config_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, tpin, treq, runin, stb, v;
  logic [7:0] img [8];
  logic [19:0] wd;
  logic expq [$];
  int errors = 0, samples_checked = 0, nrst = 0;
  wire scl, sdl, oe, so, tbit, srst, ckp, cbit, cval, byp, vup, zm, xi;
  wire [1:0] vf;
  wire [5:0] bep, yg, dg;
  wire [7:0] blk, wht;
  vcfg_pkg::vcfg_src_t gs, bs, rs;
  // Open drain with pull-up: low while either side pulls
  wire sda = ~(sdl | oe);
  vcfg_i2c_host u_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sdl));
  vcfg_output_config u_dut (.i_clk(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda),
    .o_sda_out(so), .o_sda_oe(oe), .i_teletext_or_sync_reset_pin(tpin),
    .o_teletext_bit(tbit), .o_sync_restart(srst), .i_teletext_request(treq),
    .o_teletext_request_or_clock_pin(ckp), .i_cg_runin_done(runin),
    .i_cg_bit_strobe(stb), .o_copy_gen_bit(cbit), .o_copy_gen_bit_valid(cval),
    .o_green_luma_composite_src(gs), .o_blue_composite_src(bs),
    .o_red_chroma_composite_src(rs), .o_encoder_bypass(byp), .o_burst_end_point(bep),
    .o_vertical_upscale_on(vup), .o_vertical_filter_place(vf), .o_cursor_double_size(zm),
    .o_horizontal_interp_on(xi), .o_input_black_level(blk), .o_input_white_level(wht),
    .o_luma_gain_32nds(yg), .o_colour_diff_gain_32nds(dg));
  task automatic c(input string n, input logic [7:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Unmapped places read as zero
  function automatic logic [7:0] at(input logic [7:0] a);
    at = 8'h00;
    for (int j = 0; j < 8; j++)
      if (vcfg_pkg::REG_ADDR[j] == a)
        at = img[j];
  endfunction
  task automatic put(input logic [7:0] a, d);
    for (int j = 0; j < 8; j++)
      if (vcfg_pkg::REG_ADDR[j] == a)
        img[j] = d & vcfg_pkg::REG_MASK[j];
  endtask
  // Every write carries two bytes, so the second lands one place up
  task automatic w2(input logic [7:0] a, d0, d1);
    u_host.wr(a, d0, d1);
    put(a, d0);
    put(a + 8'h01, d1);
    repeat (2) @(negedge clk);
  endtask
  task automatic rc(input logic [7:0] a);
    logic [7:0] q0, q1;
    u_host.rd(a, q0, q1);
    c("rd", q0, at(a));
    c("rd_next", q1, at(a + 8'h01));
  endtask
  task automatic chk_out;
    logic [7:0] s, t;
    s = img[4];
    t = img[5];
    c("bypass", byp, s[3]);
    c("green", gs, s[3] ? 2 : s[6] ? 1 : s[7] ? 0 : 2);
    c("blue", bs, s[3] ? 2 : s[5] ? 1 : 2);
    c("red", rs, s[3] ? 2 : s[1] ? 1 : s[4] ? 3 : 2);
    c("vup", vup, t[7]);
    c("vfil", vf, (t[7] || t[6:5] == 2'h3) ? 2'h0 : t[6:5]);
    c("zoom", zm, t[4]);
    c("horizontal_interp_on", xi, t[2]);
    c("black", blk, t[3] ? 8'h00 : 8'h10);
    c("white", wht, t[3] ? 8'hff : 8'heb);
    c("ygain", yg, 6'(6'h20 + {img[6][4], img[6][4:0]}));
    c("dgain", dg, 6'(6'h20 + {img[7][4], img[7][4:0]}));
    c("burst", bep, img[0][5:0]);
  endtask
  // Sampled mid-cycle, so each one-cycle pulse is seen exactly once and settled
  always @(negedge clk)
  begin
    if (srst === 1'b1)
      nrst++;
    if (cval === 1'b1)
      c("copy_bit", cbit, expq.size() ? expq.pop_front() : 1'bx);
  end
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial
  begin
    {rst, tpin, treq, runin, stb} = 5'h10;
    img = vcfg_pkg::REG_RST;
    v = 1'($urandom(32'h87ff0394));
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk_out();
    for (int i = 0; i < 8; i++)
      rc(vcfg_pkg::REG_ADDR[i]);
    $display("test reset done");
    for (int i = 0; i < 24; i++)
    begin
      w2(vcfg_pkg::REG_ADDR[i % 8], 8'($urandom), 8'($urandom));
      rc(vcfg_pkg::REG_ADDR[i % 8]);
      chk_out();
    end
    // Gain extremes: lowest luma, highest colour difference
    w2(8'h38, 8'h10, 8'h0f);
    chk_out();
    $display("test registers done");
    w2(8'h2d, 8'h04, 8'h00);
    repeat (3)
    begin
      v = ckp;
      @(negedge clk);
      c("clk_pin", ckp, 1'(~v));
    end
    w2(8'h2d, 8'h00, 8'h00);
    repeat (4)
    begin
      treq = 1'($urandom);
      @(negedge clk);
      c("req_pin", ckp, treq);
    end
    $display("test clock pin done");
    nrst = 0;
    w2(8'h29, 8'h1d, 8'h00);
    tpin = 1'b1;
    repeat (5) @(negedge clk);
    c("ttx_bit", tbit, 1'b1);
    tpin = 1'b0;
    w2(8'h29, 8'h9d, 8'h00);
    tpin = 1'b1;
    repeat (2) @(negedge clk);
    tpin = 1'b0;
    // The synced pin is still high here, so a stray teletext bit would show
    @(negedge clk);
    c("ttx_off", tbit, 1'b0);
    repeat (5) @(negedge clk);
    c("restarts", nrst, 1);
    $display("test sync pin done");
    w2(8'h2a, 8'($urandom), 8'($urandom));
    w2(8'h2c, 8'h80 | 8'($urandom), 8'h00);
    wd = {img[3][3:0], img[2], img[1]};
    for (int k = 0; k < 21; k++)
    begin
      runin = (k == 0);
      stb = (k > 0);
      if (k > 0)
        expq.push_back(wd[k - 1]);
      @(negedge clk);
    end
    {runin, stb} = 2'h0;
    repeat (3) @(negedge clk);
    c("copy_left", expq.size(), 0);
    // Enable off: any valid now finds an empty queue
    w2(8'h2c, 8'h0f, 8'h00);
    runin = 1'b1;
    @(negedge clk);
    {runin, stb} = 2'h1;
    repeat (3) @(negedge clk);
    stb = 1'b0;
    repeat (3) @(negedge clk);
    $display("test copy insertion done");
    c("acks", u_host.nak, 0);
    c("sda_out", so, 1'b0);
    complete_run();
  end
endmodule
